// ===== rtl/vcd_link.v
`timescale 1ns/10ps
`include "vcd_defines.vh"
module vcd_link #(
  parameter CHAN_COUNT = `VCD_CHAN_COUNT,
  parameter DATA_W     = `VCD_DATA_W,
  parameter PERIOD     = `VCD_PERIOD,
  parameter WIRES      = (CHAN_COUNT + PERIOD - 1) / PERIOD
) (
  input  wire                    core_clk,
  input  wire                    sys_rst,
  input  wire                    in_valid,
  input  wire [`VCD_CHAN_W-1:0]  in_channel,
  input  wire [DATA_W-1:0]       in_data,
  output reg                     out_valid,
  output reg  [`VCD_CHAN_W-1:0]  out_channel,
  output wire [WIRES*DATA_W-1:0] out_data,
  output reg                     frame_overrun
);
  // Per-wire channel cycles, even spread over the wires
  localparam CYCLES = (CHAN_COUNT + WIRES - 1) / WIRES;
  localparam [`VCD_CHAN_W-1:0] PER_LAST = PERIOD - 1;
  localparam [`VCD_CHAN_W-1:0] CYC_LAST = CYCLES - 1;
  localparam [`VCD_CHAN_W-1:0] CH_LAST  = CHAN_COUNT - 1;
  localparam [1:0] ST_IDLE = `VCD_ST_IDLE;
  localparam [1:0] ST_EMIT = `VCD_ST_EMIT;

  reg  [DATA_W-1:0]            cap_mem [0:CHAN_COUNT-1];
  reg  [CHAN_COUNT*DATA_W-1:0] emit_bus;
  reg  [`VCD_CHAN_W-1:0]       per_cnt;
  reg  [`VCD_CHAN_W-1:0]       slot;
  reg  [1:0]                   state;
  reg  [1:0]                   next_state;
  reg                          ready;
  wire                         frame_done;
  wire                         per_tick;
  wire                         start;
  wire                         emitting;

  // Capture by decoding valid and channel, never by counting cycles
  assign frame_done = in_valid && in_channel == CH_LAST;
  assign per_tick   = per_cnt == `VCD_CHAN_RST;
  assign start      = per_tick && ready && state == ST_IDLE;
  assign emitting   = state == ST_EMIT;

  genvar g;
  generate
    for (g = 0; g < CHAN_COUNT; g = g + 1) begin : g_chan
      localparam [`VCD_CHAN_W-1:0] CH = g;
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cap_mem[g] <= {DATA_W{1'b0}};
        end else if (in_valid && in_channel == CH) begin
          cap_mem[g] <= in_data;
        end
      end
      // Frame copy keeps the outgoing frame stable while the next fills
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          emit_bus[g*DATA_W +: DATA_W] <= {DATA_W{1'b0}};
        end else if (start) begin
          emit_bus[g*DATA_W +: DATA_W] <= cap_mem[g];
        end
      end
    end
  endgenerate

  // Frame-rate divider: one slot group every PERIOD clocks
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt <= `VCD_CHAN_RST;
    end else if (per_cnt == PER_LAST) begin
      per_cnt <= `VCD_CHAN_RST;
    end else begin
      per_cnt <= per_cnt + 8'h01;
    end
  end

  // Completion set wins over the clear taken at frame start
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready         <= 1'b0;
      frame_overrun <= 1'b0;
    end else begin
      ready         <= frame_done | (ready & ~start);
      frame_overrun <= frame_done & ready & ~start;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (slot == CYC_LAST) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      slot  <= `VCD_CHAN_RST;
    end else begin
      state <= next_state;
      if (start || slot == CYC_LAST) begin
        slot <= `VCD_CHAN_RST;
      end else if (emitting) begin
        slot <= slot + 8'h01;
      end
    end
  end

  // Valid and channel take one register stage, as the lane data does, so all leave together
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid   <= 1'b0;
      out_channel <= `VCD_CHAN_RST;
    end else begin
      out_valid   <= emitting;
      out_channel <= emitting ? slot : `VCD_CHAN_RST;
    end
  end

  generate
    for (g = 0; g < WIRES; g = g + 1) begin : g_wire
      vcd_wire_lane #(
        .CHAN_COUNT (CHAN_COUNT),
        .DATA_W     (DATA_W),
        .CYCLES     (CYCLES),
        .WIRE       (g)
      ) u_lane (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .load       (emitting),
        .slot       (slot),
        .frame_bus  (emit_bus),
        .lane_data  (out_data[g*DATA_W +: DATA_W])
      );
    end
  endgenerate
endmodule // vcd_link

// ===== rtl/vcd_defines.vh
// Overview of operation
// - Channel is 8-bit counter from zero
// - Valid high marks channel and data meaningful
// - Channel identifier stays with its sample
// - One valid/channel pair, several data wires
// - Valid, channel, data leave same cycle
// - Frame channels occupy consecutive cycles
// - Channels numbered 0 to N-1
// - One channel: channel 0, valid high at most every second cycle
// - Frame fits one cycle: counter stays zero
// - Slow rate: valid low in spare slots
// - Three slots, two channels: 0,1,idle
// - Extra wires, channels spread evenly
// - Parallel lanes muxed onto output vector
// - Merge regenerates valid and channel counters
// - Counter runs 0 to per-wire cycles minus one
// - Channel ignored while valid is low
`ifndef VCD_DEFINES_VH
`define VCD_DEFINES_VH
`define VCD_CHAN_W      8
`define VCD_CHAN_RST    8'h00
`define VCD_CHAN_COUNT  4
`define VCD_DATA_W      16
`define VCD_PERIOD      3
`define VCD_ST_IDLE     2'h1
`define VCD_ST_EMIT     2'h2
`endif

// ===== rtl/vcd_wire_lane.v
`timescale 1ns/10ps
`include "vcd_defines.vh"
module vcd_wire_lane #(
  parameter CHAN_COUNT = `VCD_CHAN_COUNT,
  parameter DATA_W     = `VCD_DATA_W,
  parameter CYCLES     = 2,
  parameter WIRE       = 0
) (
  input  wire                         core_clk,
  input  wire                         sys_rst,
  input  wire                         load,
  input  wire [`VCD_CHAN_W-1:0]       slot,
  input  wire [CHAN_COUNT*DATA_W-1:0] frame_bus,
  output reg  [DATA_W-1:0]            lane_data
);
  reg     [DATA_W-1:0] next_lane;
  integer              i;

  // Wire WIRE carries channels WIRE*CYCLES .. WIRE*CYCLES+CYCLES-1
  always @* begin
    next_lane = {DATA_W{1'b0}};
    for (i = 0; i < CYCLES; i = i + 1) begin
      if (load && slot == i[`VCD_CHAN_W-1:0] &&
          WIRE * CYCLES + i < CHAN_COUNT) begin
        next_lane = frame_bus[(WIRE*CYCLES+i)*DATA_W +: DATA_W];
      end
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lane_data <= {DATA_W{1'b0}};
    end else begin
      lane_data <= next_lane;
    end
  end
endmodule // vcd_wire_lane

// ===== verif/vcd_link_sva.sv
`timescale 1ns/10ps
module vcd_link_sva #(
  parameter WIRES  = 2,
  parameter DATA_W = 16
) (
  input wire                    core_clk,
  input wire                    sys_rst,
  input wire                    in_valid,
  input wire [7:0]              in_channel,
  input wire                    out_valid,
  input wire [7:0]              out_channel,
  input wire [WIRES*DATA_W-1:0] out_data
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_rst_quiet: assert property ($fell(sys_rst) |-> !out_valid)
    else $error("valid after reset");
  a_idle_chan: assert property (!out_valid |-> out_channel == 8'h0)
    else $error("idle chan");
  a_idle_data: assert property (!out_valid |-> out_data == 0)
    else $error("idle data");
  a_chan_range: assert property (out_valid |-> out_channel < 8'h2)
    else $error("chan range");
  a_first_slot: assert property ($rose(out_valid) |-> !out_channel)
    else $error("first slot");
  a_slot_step: assert property (out_valid && !out_channel
    |=> out_valid && out_channel == 8'h1) else $error("slot step");
  a_spare_slot: assert property (out_valid && out_channel
    |=> !out_valid) else $error("spare slot");
  a_emit_bound: assert property (in_valid && in_channel == 8'h3
    |-> ##[2:7] out_valid) else $error("emit late");
endmodule // vcd_link_sva
bind vcd_link vcd_link_sva #(.WIRES(WIRES), .DATA_W(DATA_W)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .in_valid(in_valid),
  .in_channel(in_channel), .out_valid(out_valid),
  .out_channel(out_channel), .out_data(out_data));

// ===== verif/vcd_producer.sv
`timescale 1ns/10ps
module vcd_producer (
  input  wire         core_clk,
  output logic        in_valid = 1'b0,
  output logic [7:0]  in_channel = 8'h0,
  output logic [15:0] in_data = 16'h0
);
  task send(input logic [63:0] f, input int gap);
    for (int c = 0; c < 4; c++) begin
      @(negedge core_clk);
      in_valid = 1'b1;
      in_channel = c[7:0];
      in_data = f[c*16 +: 16];
    end
    // Stale lines inverted each idle cycle, so the old value returns every second cycle
    repeat (gap + 1) begin
      @(negedge core_clk);
      in_valid = 1'b0;
      in_channel = ~in_channel;
      in_data = ~in_data;
    end
  endtask
endmodule // vcd_producer

// ===== verif/vcd_link_test.sv
`timescale 1ns/10ps
module vcd_link_test;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        in_valid;
  logic [7:0]  in_channel;
  logic [15:0] in_data;
  logic        out_valid;
  logic [7:0]  out_channel;
  logic [31:0] out_data;
  logic        frame_overrun;
  logic [31:0] seed = 32'h0b6d;
  logic [63:0] q[$];
  logic [63:0] fr;
  int          err_total = 0;
  int          samples_checked = 0;
  int          sl = 0;
  vcd_link dut (.core_clk(core_clk), .sys_rst(sys_rst), .in_valid(in_valid),
    .in_channel(in_channel), .in_data(in_data), .out_valid(out_valid),
    .out_channel(out_channel), .out_data(out_data),
    .frame_overrun(frame_overrun));
  vcd_producer u_prod (.core_clk(core_clk), .in_valid(in_valid),
    .in_channel(in_channel), .in_data(in_data));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task drain();
    for (int n = 0; n < 40 && q.size() > 0; n++)
      @(negedge core_clk);
    if (q.size() > 0) begin
      err_total++;
      test_done();
    end
  endtask
  // Channel c of a frame sits on wire c/2, slot c%2
  always @(negedge core_clk) begin
    if (!sys_rst) begin
      chk("overrun", 32'h0, {31'h0, frame_overrun});
      if (out_valid !== 1'b0) begin
        chk("chan", sl, {24'h0, out_channel});
        chk("data", {q[0][(sl+2)*16 +: 16], q[0][sl*16 +: 16]}, out_data);
        sl = sl ^ 1;
        if (sl == 0)
          void'(q.pop_front());
      end
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      fr = {rnd(), rnd()};
      q.push_back(fr);
      // Next frame may not refill a slot before the pending copy is taken
      u_prod.send(fr, 1 + rnd() % 3);
    end
    drain();
    $display("frames test done");
    // Frame closed and pending but not yet copied for emission when reset hits
    u_prod.send({rnd(), rnd()}, 0);
    sys_rst = 1'b1;
    sl = 0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    fr = {rnd(), rnd()};
    q.push_back(fr);
    u_prod.send(fr, 0);
    drain();
    $display("reset test done");
    test_done();
  end
endmodule // vcd_link_test
